// ---- slpm_bank.sv ----
/*
 * One bank's open-row flag.
 * Assumes the parent only passes commands that the device accepts.
 */
`timescale 1ns/1ps
module slpm_bank (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic act_i,
	input wire logic pre_i,
	input wire logic clr_i,
	output logic open_o
);
	logic open_ff;
	always_ff @(posedge clk_i) begin
		if (!rstn_i || clr_i)
			open_ff <= 1'b0;
		else if (act_i)
			open_ff <= 1'b1;
		else if (pre_i)
			open_ff <= 1'b0;
	end
	assign open_o = open_ff;
endmodule // slpm_bank

// ---- slpm_ctrl_model.sv ----
/*
 * Controller-side model: clock enable, command pins, address and true clock.
 * Assumes the bench calls its tasks just after a rising edge of clk_i.
 */
`timescale 1ns/1ps
module slpm_ctrl_model (
	input wire logic clk_i,
	output logic cke_o,
	output logic [3:0] cmd_o,
	output logic [slpm_pkg::SLPM_AW-1:0] addr_o,
	output logic [1:0] ba_o,
	output logic ck_true_o
);
	import slpm_pkg::*;
	initial begin
		cke_o = 1'h1;
		cmd_o = SLPM_CMD_NOP;
		addr_o = '0;
		ba_o = 2'h0;
		ck_true_o = 1'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// banks closed first
	task op(input logic cke, input logic [3:0] cmd, input logic a10, input logic [1:0] ba);
		cke_o = cke;
		cmd_o = cmd;
		ba_o = ba;
		// Unselected address must not look stable
		addr_o = cmd[3] ? ~addr_o : {2'h0, a10, 10'h0};
		@(posedge clk_i);
		#1;
	endtask
	// bursts done, clock low, enable high
	task stop(input logic on);
		cke_o = 1'h1;
		cmd_o = SLPM_CMD_NOP;
		ck_true_o = ~on;
		@(posedge clk_i);
		#1;
	endtask
endmodule // slpm_ctrl_model

// ---- slpm_pkg.sv ----
/*
 * Constants and types for the low-power mode tracker of a mobile DDR memory.
 * Assumes a single 10 MHz command clock and command pins sampled on its rising edge.
 */
package slpm_pkg;

	// Command pin pattern {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] SLPM_CMD_NOP = 4'h7;
	localparam logic [3:0] SLPM_CMD_ACT = 4'h3;
	localparam logic [3:0] SLPM_CMD_PRE = 4'h2;
	localparam logic [3:0] SLPM_CMD_REF = 4'h1;
	localparam logic [3:0] SLPM_CMD_OFF = 4'h6;
	localparam logic SLPM_DESEL = 1'h1;

	localparam int SLPM_BANKS = 4;
	localparam int SLPM_A10 = 10;
	localparam int SLPM_AW = 13;
	localparam int SLPM_PARSEL_W = 3;

	// Clock period and exit intervals, in ns
	localparam int SLPM_CLK_NS = 100;
	localparam int SLPM_TXSR_NS = 200;
	localparam int SLPM_TXP_NS = 25;
	localparam int SLPM_XSR_MIN_CYC = 2;
	localparam int SLPM_XSR_CYC_R = (SLPM_TXSR_NS + SLPM_CLK_NS - 1) / SLPM_CLK_NS;
	localparam int SLPM_XSR_CYC = (SLPM_XSR_CYC_R < SLPM_XSR_MIN_CYC) ?
		SLPM_XSR_MIN_CYC : SLPM_XSR_CYC_R;
	localparam int SLPM_XP_CYC_R = (SLPM_TXP_NS + SLPM_CLK_NS - 1) / SLPM_CLK_NS;
	localparam int SLPM_XP_CYC = (SLPM_XP_CYC_R < 1) ? 1 : SLPM_XP_CYC_R;
	localparam int SLPM_CNT_W = 4;

	// Self-refresh tick interval, nominal and hot, in cycles
	localparam int SLPM_SR_COOL_CYC = 16;
	localparam int SLPM_SR_HOT_CYC = 8;
	localparam int SLPM_ROW_W = 4;

	typedef enum logic [2:0] {
		SLPM_IDLE = 3'h0,
		SLPM_PPD = 3'h1,
		SLPM_APD = 3'h3,
		SLPM_SREF = 3'h2,
		SLPM_EXIT = 3'h6,
		SLPM_OFF = 3'h7,
		SLPM_CSTOP = 3'h5
	} slpm_state_e;

endpackage

// ---- slpm_tb_top.sv ----
/*
 * Self-checking bench for the low-power mode tracker.
 * Assumes the controller model drives all command-side inputs.
 */
`timescale 1ns/1ps
module slpm_tb_top;
	import slpm_pkg::*;
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic [2:0] part_sel = 3'h3;
	logic hot = 1'h0;
	logic cke, ck, tick, buf_en, lost, busy;
	logic [3:0] cmd, bopen, row;
	logic [SLPM_AW-1:0] addr;
	logic [1:0] ba;
	logic [2:0] st;
	int bad_count = 0;
	int samples_checked = 0;
	always #50 clk_i = ~clk_i;
	slpm_ctrl_model m (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .addr_o(addr), .ba_o(ba),
		.ck_true_o(ck));
	slpm_top slpm_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .cke_i(cke), .cs_n_i(cmd[3]),
		.ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .addr_i(addr), .ba_i(ba),
		.ck_true_i(ck), .partial_array_refresh_select_i(part_sel), .temp_hot_i(hot),
		.lp_state_o(st), .buf_en_o(buf_en), .data_lost_o(lost), .exit_busy_o(busy),
		.bank_open_o(bopen), .sref_tick_o(tick), .sref_row_o(row));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] s, input logic [7:0] e, input string msg);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// Bounded wait on state (sel 0) or open banks (sel 1)
	task wt(input logic sel, input logic [3:0] e, input int lim, output int n);
		n = 0;
		while ((sel ? bopen : {1'h0, st}) !== e && n < lim) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk({4'h0, sel ? bopen : {1'h0, st}}, {4'h0, e}, "wait");
	endtask
	task tg(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (tick !== 1'h1 && n < 40);
	endtask
	task exit_to_idle(input int cyc);
		int n;
		m.op(1'h1, SLPM_CMD_NOP, 1'h0, 2'h0);
		wt(1'h0, {1'h0, SLPM_EXIT}, 3, n);
		chk(busy, 1'h1, "busy");
		wt(1'h0, {1'h0, SLPM_IDLE}, 10, n);
		chk(8'(n), 8'(cyc), "exit length");
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_sref;
		int n;
		logic [3:0] r;
		m.op(1'h0, SLPM_CMD_REF, 1'h0, 2'h0);
		wt(1'h0, {1'h0, SLPM_SREF}, 3, n);
		chk(buf_en, 1'h0, "buffers");
		m.op(1'h0, SLPM_CMD_ACT, 1'h0, 2'h1);
		tg(n);
		r = row;
		tg(n);
		chk(8'(n), 8'(SLPM_SR_COOL_CYC), "cool gap");
		chk(row, {3'h0, ~r[0]}, "row wrap");
		hot = 1'h1;
		part_sel = 3'h0;
		tg(n);
		tg(n);
		chk(8'(n), 8'(SLPM_SR_HOT_CYC), "hot gap");
		chk(row, 4'h2, "full range");
		chk(bopen, 4'h0, "ignored act");
		exit_to_idle(SLPM_XSR_CYC);
		$display("self refresh done");
	endtask
	task t_pd;
		int n;
		m.op(1'h0, SLPM_CMD_NOP, 1'h0, 2'h0);
		wt(1'h0, {1'h0, SLPM_PPD}, 3, n);
		chk(buf_en, 1'h0, "buffers");
		exit_to_idle(SLPM_XP_CYC);
		m.op(1'h1, SLPM_CMD_ACT, 1'h0, 2'h1);
		wt(1'h1, 4'h2, 4, n);
		m.op(1'h0, SLPM_CMD_NOP, 1'h0, 2'h0);
		wt(1'h0, {1'h0, SLPM_APD}, 3, n);
		exit_to_idle(SLPM_XP_CYC);
		chk(bopen, 4'h2, "row kept");
		m.op(1'h1, SLPM_CMD_PRE, 1'h1, 2'h0);
		wt(1'h1, 4'h0, 4, n);
		$display("power-down done");
	endtask
	task t_off;
		int n;
		m.op(1'h0, SLPM_CMD_OFF, 1'h0, 2'h0);
		wt(1'h0, {1'h0, SLPM_OFF}, 3, n);
		chk(lost, 1'h1, "lost");
		m.op(1'h0, SLPM_CMD_ACT, 1'h0, 2'h0);
		chk(st, SLPM_OFF, "held");
		m.op(1'h1, 4'hf, 1'h0, 2'h0);
		wt(1'h0, {1'h0, SLPM_IDLE}, 3, n);
		chk(lost, 1'h1, "lost kept");
		m.stop(1'h1);
		wt(1'h0, {1'h0, SLPM_CSTOP}, 4, n);
		chk(buf_en, 1'h1, "buffers");
		m.stop(1'h0);
		chk(st, SLPM_IDLE, "clock restart");
		m.op(1'h1, SLPM_CMD_NOP, 1'h0, 2'h0);
		wt(1'h0, {1'h0, SLPM_IDLE}, 4, n);
		rstn_i = 1'h0;
		@(posedge clk_i);
		#1;
		rstn_i = 1'h1;
		chk({st, buf_en, lost, busy}, 8'h04, "mid reset");
		$display("power-off and clock stop done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		#1;
		rstn_i = 1'h1;
		chk({st, buf_en, lost, busy}, 8'h04, "reset");
		t_sref();
		t_pd();
		t_off();
		close_out();
	end
endmodule // slpm_tb_top

// ---- slpm_top.sv ----
/*
 * Low-power mode tracker of a mobile DDR memory device.
 * Assumes command, address and clock enable synchronous to clk_i; the
 * controller keeps its own side of every exit and entry sequence.
 */
// Behaviour
// - Refresh with clock enable low enters self refresh
// - Self refresh ignores all inputs but enable, partial select and temperature
// - Self refresh refreshes selected part, temperature rate
// - Enable low gives precharge or active power-down
// - Power-down disables all buffers except enable
// - Enable high with nop exits power-down
// - Power-off command with enable low clears data
`timescale 1ns/1ps
module slpm_top
	import slpm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [slpm_pkg::SLPM_AW-1:0] addr_i,
	input wire logic [1:0] ba_i,
	input wire logic ck_true_i,
	input wire logic [slpm_pkg::SLPM_PARSEL_W-1:0] partial_array_refresh_select_i,
	input wire logic temp_hot_i,
	output logic [2:0] lp_state_o,
	output logic buf_en_o,
	output logic data_lost_o,
	output logic exit_busy_o,
	output logic [slpm_pkg::SLPM_BANKS-1:0] bank_open_o,
	output logic sref_tick_o,
	output logic [slpm_pkg::SLPM_ROW_W-1:0] sref_row_o
);
	import slpm_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Command decode
	logic [3:0] cmd;
	wire desel = (cs_n_i == SLPM_DESEL);
	wire is_nop = desel || (cmd == SLPM_CMD_NOP);
	wire is_act = !desel && (cmd == SLPM_CMD_ACT);
	wire is_pre = !desel && (cmd == SLPM_CMD_PRE);
	wire is_ref = !desel && (cmd == SLPM_CMD_REF);
	wire is_off = !desel && (cmd == SLPM_CMD_OFF);
	assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};

	slpm_state_e state_ff, nxt_state;
	logic [SLPM_CNT_W-1:0] exit_cnt_ff, nxt_exit_cnt;
	logic [SLPM_BANKS-1:0] bank_open;
	logic data_lost_ff;
	logic ck_low_ff;

	wire any_open = |bank_open;
	wire in_idle = (state_ff == SLPM_IDLE) || (state_ff == SLPM_CSTOP);
	wire cmd_live = in_idle && cke_i;

	////////////////////////////////////////////////////////////////////
	// Banks
	genvar g;
	generate
		for (g = 0; g < SLPM_BANKS; g++) begin : g_bank
			wire act_hit = cmd_live && is_act && (ba_i == 2'(g));
			wire pre_hit = cmd_live && is_pre && (addr_i[SLPM_A10] || ba_i == 2'(g));
			// Row kept open across active power-down
			slpm_bank u_bank (
				.clk_i(clk_i),
				.rstn_i(rstn_i),
				.act_i(act_hit),
				.pre_i(pre_hit),
				.clr_i(state_ff == SLPM_OFF),
				.open_o(bank_open[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Mode state machine
	always_comb begin
		nxt_state = state_ff;
		nxt_exit_cnt = (exit_cnt_ff != '0) ? exit_cnt_ff - 1'b1 : exit_cnt_ff;
		case (state_ff)
			SLPM_IDLE, SLPM_CSTOP: begin
				if (!cke_i && is_ref && !any_open) begin
					nxt_state = SLPM_SREF;
				end else if (!cke_i && is_off && !any_open) begin
					nxt_state = SLPM_OFF;
				end else if (!cke_i) begin
					nxt_state = any_open ? SLPM_APD : SLPM_PPD;
				end else if (ck_low_ff && !ck_true_i) begin
					// Enable high and clock parked low
					nxt_state = SLPM_CSTOP;
				end else begin
					nxt_state = SLPM_IDLE;
				end
			end
			SLPM_PPD, SLPM_APD: begin
				if (cke_i && is_nop) begin
					nxt_state = SLPM_EXIT;
					nxt_exit_cnt = SLPM_CNT_W'(SLPM_XP_CYC);
				end
			end
			SLPM_SREF: begin
				if (cke_i) begin
					nxt_state = SLPM_EXIT;
					nxt_exit_cnt = SLPM_CNT_W'(SLPM_XSR_CYC);
				end
			end
			SLPM_OFF: begin
				// Leave power-off on enable high with nop
				if (cke_i && is_nop)
					nxt_state = SLPM_IDLE;
			end
			SLPM_EXIT: begin
				if (exit_cnt_ff <= SLPM_CNT_W'(1))
					nxt_state = SLPM_IDLE;
			end
			default: nxt_state = SLPM_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_ff <= SLPM_IDLE;
			exit_cnt_ff <= '0;
			ck_low_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			exit_cnt_ff <= nxt_exit_cnt;
			ck_low_ff <= !ck_true_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			data_lost_ff <= 1'b0;
		else if (nxt_state == SLPM_OFF)
			data_lost_ff <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// Self-refresh engine
	logic [4:0] sr_cnt_ff;
	logic [SLPM_ROW_W-1:0] row_ff;
	logic tick_ff;
	logic [SLPM_ROW_W-1:0] row_lim;
	wire in_sref = (state_ff == SLPM_SREF);
	wire [4:0] sr_period = temp_hot_i ? 5'(SLPM_SR_HOT_CYC) : 5'(SLPM_SR_COOL_CYC);
	wire sr_fire = in_sref && (sr_cnt_ff >= sr_period - 5'h1);
	// Refresh range set by partial select
	assign row_lim = {SLPM_ROW_W{1'b1}} >> partial_array_refresh_select_i[1:0];
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !in_sref) begin
			sr_cnt_ff <= '0;
			row_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			sr_cnt_ff <= sr_fire ? 5'h0 : sr_cnt_ff + 5'h1;
			tick_ff <= sr_fire;
			if (sr_fire)
				row_ff <= (row_ff >= row_lim) ? '0 : row_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	logic buf_en_ff, exit_busy_ff;
	logic [SLPM_BANKS-1:0] bank_open_ff;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			buf_en_ff <= 1'b1;
			exit_busy_ff <= 1'b0;
			bank_open_ff <= '0;
		end else begin
			buf_en_ff <= (nxt_state == SLPM_IDLE) || (nxt_state == SLPM_CSTOP)
				|| (nxt_state == SLPM_EXIT);
			exit_busy_ff <= (nxt_state == SLPM_EXIT);
			bank_open_ff <= bank_open;
		end
	end
	assign lp_state_o = state_ff;
	assign buf_en_o = buf_en_ff;
	assign data_lost_o = data_lost_ff;
	assign exit_busy_o = exit_busy_ff;
	assign bank_open_o = bank_open_ff;
	assign sref_tick_o = tick_ff;
	assign sref_row_o = row_ff;

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_sr_cmd;
		in_idle && !cke_i && is_ref && !any_open;
	endsequence
	sequence s_sr_wait;
		(state_ff == SLPM_EXIT) [*2];
	endsequence

	chk_sref_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_sr_cmd |=> state_ff == SLPM_SREF)
		else $error("self refresh not entered");
	chk_sref_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(in_sref && !cke_i) |=> in_sref && $stable(bank_open))
		else $error("self refresh left while enable low");
	chk_sref_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(tick_ff && in_sref && temp_hot_i && $stable(temp_hot_i) && !cke_i)
		|-> ##1 !tick_ff [*7])
		else $error("hot refresh ticks too close");
	chk_pd_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(in_idle && !cke_i && !is_ref && !is_off)
		|=> state_ff == ($past(any_open) ? SLPM_APD : SLPM_PPD))
		else $error("wrong power-down flavour");
	chk_buf_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(state_ff == SLPM_PPD || state_ff == SLPM_APD) |-> !buf_en_o)
		else $error("buffers on in power-down");
	chk_pd_exit: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(state_ff == SLPM_PPD && cke_i && is_nop) |=> exit_busy_o ##[1:3] state_ff == SLPM_IDLE)
		else $error("power-down exit wrong");
	chk_off_lost: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(in_idle && !cke_i && is_off && !any_open)
		|=> state_ff == SLPM_OFF && data_lost_o ##1 data_lost_o && bank_open == '0)
		else $error("power-off not taken");
	chk_apd_rows: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(state_ff == SLPM_APD) |=> $stable(bank_open))
		else $error("rows changed in power-down");
	chk_sr_exit: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(in_sref && cke_i) |=> s_sr_wait ##1 state_ff == SLPM_IDLE)
		else $error("self refresh exit too short");

endmodule // slpm_top
